// [dds_host_model.sv]
// host serial port model for the three-wire write link
`timescale 1ns/1ps
module dds_host_model (
	output logic serial_clk,
	output logic frame_sync_n,
	output logic serial_data
);
	bit idle_hi = 0; // clock rest level between frames
	initial begin
		serial_clk = 0;
		frame_sync_n = 1;
		serial_data = 0;
	end
	// select the device half a bit before the first rise
	task open_frame;
		frame_sync_n = 0;
		#24;
	endtask
	// msb first, data moves on the rise and is taken on the fall
	task automatic send(input logic [15:0] w, input int n);
		for (int i = 15; i > 15 - n; i--) begin
			serial_data = w[i];
			serial_clk = 1;
			#24 serial_clk = 0;
			#24;
		end
	endtask
	// deselect after the last fall; a released data line must not look valid
	task close_frame;
		frame_sync_n = 1;
		serial_data = ~serial_data;
		serial_clk = idle_hi;
		#48;
	endtask
	// activity while deselected
	task stray(input int n);
		repeat (n) begin
			serial_clk = ~serial_clk;
			serial_data = ~serial_data;
			#24;
		end
	endtask
endmodule

// [dds_serial_control_load.v]
// serial write port, control decoder and register loader of a dds core
`timescale 1ns/1ps
`include "dds_serial_defines.vh"

module dds_serial_control_load (
	input wire clk_sys,
	input wire rst_n,
	input wire serial_clk,
	input wire frame_sync_n,
	input wire serial_data,
	input wire freq_choice_pin,
	input wire phase_choice_pin,
	input wire reset_pin,
	input wire sleep_pin,
	output reg [`HALF_BITS-1:0] control_bits_q,
	output reg [`FREQ_BITS-1:0] frequency_word_a_q,
	output reg [`FREQ_BITS-1:0] frequency_word_b_q,
	output reg [`PHASE_BITS-1:0] phase_offset_a_q,
	output reg [`PHASE_BITS-1:0] phase_offset_b_q,
	output reg [`FREQ_BITS-1:0] active_freq_q,
	output reg [`PHASE_BITS-1:0] active_phase_q,
	output reg accum_clear_q,
	output reg accum_run_q,
	output reg output_live_q
);
	// loader states, one-hot
	localparam ST_IDLE = 2'b01;
	localparam ST_LOW_HELD = 2'b10;

	// the host link and the select pins are all foreign to clk_sys;
	// every one of them goes through the same two-flop bank so that
	// a data bit and its clock edge are seen with the same delay.
	// the cost is two cycles of latency on every pin, which come on
	// top of the depth of the latency pipeline below.
	// rst_n itself is not synchronised: it only clears, never steers.
	// pipeline width for the selected frequency and phase pair
	localparam SEL_W = `FREQ_BITS + `PHASE_BITS;

	// synchronised pins; frame sync is inverted so idle reads zero
	wire [6:0] pins_raw;
	wire [6:0] pins_s;
	wire sclk_s;
	wire frame_on_s;
	wire sdata_s;
	wire fpin_s;
	wire ppin_s;
	wire rpin_s;
	wire spin_s;

	// serial shift state
	reg sclk_prev_q; // last synchronised serial clock level
	reg [`WORD_BITS-1:0] shift_q; // input shift register
	reg [`BIT_CNT_W-1:0] bit_cnt_q; // bits taken in this word
	reg word_ready_q; // one-cycle pulse, word in shift_q complete
	wire sclk_fall;
	wire [`WORD_BITS-1:0] shift_next;

	// loader state
	reg [1:0] load_state_q;
	reg [1:0] load_state_d;
	reg [`HALF_BITS-1:0] low_half_q; // held low half in full mode
	reg [1:0] low_dest_q; // destination of the held low half

	// decoded word fields
	wire [1:0] dest;
	wire [`HALF_BITS-1:0] payload;
	wire full_mode;
	wire half_upper;

	// effective controls after source selection
	reg ctl_sample_q; // marks the sampling stage is loaded
	reg [`HALF_BITS-1:0] ctl_sampled_q; // sampled control bits
	wire use_pins;
	wire freq_sel;
	wire phase_sel;
	wire core_reset;
	wire core_halt;
	wire [SEL_W-1:0] sel_pair;
	wire [SEL_W-1:0] sel_pair_dly;
	wire reset_dly;

	// all external pins cross into clk_sys through two flops
	assign pins_raw = {~frame_sync_n, serial_clk, serial_data,
		freq_choice_pin, phase_choice_pin, reset_pin, sleep_pin};

	pin_sync #(
		.W(7)
	) u_pin_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.pin_in(pins_raw),
		.pin_sync_q(pins_s)
	);

	assign frame_on_s = pins_s[6];
	assign sclk_s = pins_s[5];
	assign sdata_s = pins_s[4];
	assign fpin_s = pins_s[3];
	assign ppin_s = pins_s[2];
	assign rpin_s = pins_s[1];
	assign spin_s = pins_s[0];

	// falling edge of the serial clock as seen in clk_sys
	// a free-running or idle-high/low clock all look alike here
	assign sclk_fall = sclk_prev_q & ~sclk_s;

	// new bit enters at the bottom, so the first bit ends on top
	assign shift_next = {shift_q[`WORD_BITS-2:0], sdata_s};

	// the bit counter runs only while frame sync is seen low, so a
	// long frame simply wraps it every sixteen bits and each wrap
	// raises the word strobe. a frame that closes early clears the
	// count and leaves shift_q holding junk that nobody reads,
	// because only the strobe lets a word into the loader.
	// limitation: a serial clock phase shorter than ~1 clk_sys cycle is missed.
	// serial shifter and bit counter
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sclk_prev_q <= 1'b0;
			shift_q <= {`WORD_BITS{1'b0}};
			bit_cnt_q <= `BIT_CNT_RST;
			word_ready_q <= 1'b0;
		end else begin
			sclk_prev_q <= sclk_s;
			word_ready_q <= 1'b0;
			if (!frame_on_s) begin
				// frame closed: any partial word is dropped
				bit_cnt_q <= `BIT_CNT_RST;
			end else if (sclk_fall) begin
				shift_q <= shift_next;
				if (bit_cnt_q == `BIT_CNT_LAST - 5'h0_001) begin
					// sixteenth bit closes a word; the next bit starts another
					bit_cnt_q <= `BIT_CNT_RST;
					word_ready_q <= 1'b1;
				end else begin
					bit_cnt_q <= bit_cnt_q + 5'h0_001;
				end
			end
		end
	end

	// word fields
	assign dest = shift_q[`DEST_HI:`DEST_LO];
	assign payload = shift_q[`HALF_BITS-1:0];
	assign full_mode = control_bits_q[`CTL_FULL_WORD];
	assign half_upper = control_bits_q[`CTL_HALF_SEL];

	// full-word pairing: the first frequency word is parked in
	// low_half_q and the register is left alone until the second
	// word arrives, so the accumulator never sees a torn value.
	// any word at all ends a pairing, which keeps the loader from
	// waiting forever on a host that changed its mind mid pair.
	// phase and control words never start a pair.
	// loader next state: pairing only exists in full mode
	always @* begin
		load_state_d = load_state_q;
		case (load_state_q)
			ST_IDLE: begin
				if (word_ready_q && full_mode && dest != `DEST_CONTROL
					&& dest != `DEST_PHASE) begin
					load_state_d = ST_LOW_HELD;
				end
			end
			ST_LOW_HELD: begin
				if (word_ready_q) begin
					// a control write also ends the pair, mode may change
					load_state_d = ST_IDLE;
				end
			end
			default: begin
				load_state_d = ST_IDLE;
			end
		endcase
	end

	// register loads
	// a mismatched second destination commits to the second one
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			load_state_q <= ST_IDLE;
			control_bits_q <= `CTL_RST_VAL;
			frequency_word_a_q <= `FREQ_RST_VAL;
			frequency_word_b_q <= `FREQ_RST_VAL;
			phase_offset_a_q <= `PHASE_RST_VAL;
			phase_offset_b_q <= `PHASE_RST_VAL;
			low_half_q <= `HALF_RST_VAL;
			low_dest_q <= `DEST_CONTROL;
		end else begin
			load_state_q <= load_state_d;
			if (word_ready_q) begin
				case (dest)
					`DEST_CONTROL: begin
						control_bits_q <= payload;
					end
					`DEST_FREQ_A, `DEST_FREQ_B: begin
						if (full_mode && load_state_q == ST_IDLE) begin
							// first half is held, register untouched
							low_half_q <= payload;
							low_dest_q <= dest;
						end else if (full_mode) begin
							// second half commits both halves together
							if (dest == `DEST_FREQ_A) begin
								frequency_word_a_q <= {payload, low_half_q};
							end else begin
								frequency_word_b_q <= {payload, low_half_q};
							end
						end else if (half_upper) begin
							// half mode, upper half only
							if (dest == `DEST_FREQ_A) begin
								frequency_word_a_q[`FREQ_BITS-1:`HALF_BITS] <= payload;
							end else begin
								frequency_word_b_q[`FREQ_BITS-1:`HALF_BITS] <= payload;
							end
						end else begin
							// half mode, lower half only
							if (dest == `DEST_FREQ_A) begin
								frequency_word_a_q[`HALF_BITS-1:0] <= payload;
							end else begin
								frequency_word_b_q[`HALF_BITS-1:0] <= payload;
							end
						end
					end
					`DEST_PHASE: begin
						// one bit picks the phase register, low bits carry it
						if (payload[`PHASE_SEL_BIT]) begin
							phase_offset_b_q <= payload[`PHASE_BITS-1:0];
						end else begin
							phase_offset_a_q <= payload[`PHASE_BITS-1:0];
						end
					end
					default: begin
						control_bits_q <= control_bits_q;
					end
				endcase
			end
		end
	end

	// the control word is written from the serial side at any time;
	// one extra stage stands in for the falling-edge sampling of the
	// master clock, so a fresh control word steers the core one
	// cycle after it lands. ctl_sample_q marks that the stage holds
	// a real value, which keeps accumulation off for that first cycle.
	// control bits pass one sampling stage before they steer the core; full_mode and half_upper skip it
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctl_sample_q <= 1'b0;
			ctl_sampled_q <= `CTL_RST_VAL;
		end else begin
			ctl_sample_q <= 1'b1;
			ctl_sampled_q <= control_bits_q;
		end
	end

	// choose pins or control bits as the source of select, reset, sleep
	assign use_pins = ctl_sampled_q[`CTL_SOURCE];
	assign freq_sel = use_pins ? fpin_s : ctl_sampled_q[`CTL_FREQ_CHOICE];
	assign phase_sel = use_pins ? ppin_s : ctl_sampled_q[`CTL_PHASE_CHOICE];
	assign core_reset = use_pins ? rpin_s : ctl_sampled_q[`CTL_RESET];
	// the halt bit always acts; the sleep pin adds to it in pin mode
	assign core_halt = ctl_sampled_q[`CTL_HALT] | (use_pins & spin_s);

	// frequency and phase travel as one word through one pipeline so
	// that a select change moves both together; a split pipeline
	// could show a new frequency with the old phase for a cycle.
	// the delay line is one stage short of the latency because the
	// output flop below supplies the last stage.
	// selected pair enters the pipeline; the output flop is the last stage
	assign sel_pair = {freq_sel ? frequency_word_b_q : frequency_word_a_q,
		phase_sel ? phase_offset_b_q : phase_offset_a_q};

	delay_line #(
		.W(SEL_W),
		.D(`SELECT_LATENCY - 1)
	) u_sel_delay (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.din(sel_pair),
		.dout(sel_pair_dly)
	);

	// reset release is delayed the same way as selection
	delay_line #(
		.W(1),
		.D(`RELEASE_LATENCY - 1)
	) u_rst_delay (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.din(core_reset),
		.dout(reset_dly)
	);

	// clear is taken from both the live and the delayed reset, so the
	// accumulators go clear at once and stay clear until the release
	// has walked the whole pipeline. output_live_q is the inverse of
	// the same pair: it drops at once and rises only at the end.
	// the loaded frequency, phase and control registers are never
	// touched here; only rst_n clears them.
	// output stage: clear acts at once, release waits out the pipeline
	// the halt freezes the active words instead of gating clk_sys,
	// which keeps the whole block on one clock tree
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			active_freq_q <= `FREQ_RST_VAL;
			active_phase_q <= `PHASE_RST_VAL;
			accum_clear_q <= 1'b1;
			accum_run_q <= 1'b0;
			output_live_q <= 1'b0;
		end else begin
			// loaded registers are untouched by the core reset
			accum_clear_q <= core_reset | reset_dly;
			accum_run_q <= ~core_halt & ctl_sample_q;
			output_live_q <= ~core_reset & ~reset_dly;
			if (!core_halt) begin
				active_freq_q <= sel_pair_dly[SEL_W-1:`PHASE_BITS];
				active_phase_q <= sel_pair_dly[`PHASE_BITS-1:0];
			end
		end
	end
endmodule

// [dds_serial_control_load_props.sv]
// assertion checker for the dds serial control loader
`timescale 1ns/1ps
`include "dds_serial_defines.vh"
module dds_serial_control_load_props (
	input wire clk_sys,
	input wire rst_n,
	input wire freq_choice_pin,
	input wire reset_pin,
	input wire sleep_pin,
	input wire [`HALF_BITS-1:0] control_bits_q,
	input wire [`FREQ_BITS-1:0] frequency_word_a_q,
	input wire [`FREQ_BITS-1:0] frequency_word_b_q,
	input wire [`FREQ_BITS-1:0] active_freq_q,
	input wire accum_clear_q,
	input wire accum_run_q,
	input wire output_live_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// software mode, running, core reset off
	wire sw = !control_bits_q[9] && !control_bits_q[7] && !control_bits_q[8];
	// pin mode with no halt source
	wire pw = control_bits_q[9] && !control_bits_q[7] && !sleep_pin;
	wire [27:0] pick = control_bits_q[11] ? frequency_word_b_q : frequency_word_a_q;
	wire [27:0] pin_pick = freq_choice_pin ? frequency_word_b_q : frequency_word_a_q;
	a_bit_choice: assert property (sw && $changed(control_bits_q[11]) |-> ##8
		(!sw || active_freq_q == pick)) else $error("choice bit late");
	a_reg_reload: assert property (sw && !control_bits_q[11] && $changed(frequency_word_a_q)
		|-> ##7 (!sw || active_freq_q == frequency_word_a_q)) else $error("reload late");
	a_pin_choice: assert property (pw && $changed(freq_choice_pin) |-> ##[9:10]
		(!pw || active_freq_q == pin_pick)) else $error("pin choice late");
	a_bit_clear: assert property (!control_bits_q[9] && $rose(control_bits_q[8]) |->
		##[1:3] accum_clear_q) else $error("reset bit ignored");
	a_bit_release: assert property (!control_bits_q[9] && $fell(control_bits_q[8]) |->
		!output_live_q [*6] ##[1:3] output_live_q) else $error("bit release latency");
	a_pin_clear: assert property (control_bits_q[9] && $rose(reset_pin) |->
		##[1:4] accum_clear_q) else $error("reset pin ignored");
	a_pin_release: assert property (control_bits_q[9] && $fell(reset_pin) |->
		!output_live_q [*6] ##[1:5] output_live_q) else $error("pin release latency");
	a_halt_freeze: assert property (control_bits_q[7] && $past(control_bits_q[7], 3) |->
		$stable(active_freq_q) && !accum_run_q) else $error("halt did not freeze");
endmodule
bind dds_serial_control_load dds_serial_control_load_props u_props (.clk_sys(clk_sys),
	.rst_n(rst_n), .freq_choice_pin(freq_choice_pin), .reset_pin(reset_pin),
	.sleep_pin(sleep_pin), .control_bits_q(control_bits_q),
	.frequency_word_a_q(frequency_word_a_q), .frequency_word_b_q(frequency_word_b_q),
	.active_freq_q(active_freq_q), .accum_clear_q(accum_clear_q),
	.accum_run_q(accum_run_q), .output_live_q(output_live_q));

// [dds_serial_defines.vh]
// constants for the dds serial write port and control decoder
`ifndef DDS_SERIAL_DEFINES_VH
`define DDS_SERIAL_DEFINES_VH

// serial word shape
`define WORD_BITS 16
`define BIT_CNT_W 5
`define BIT_CNT_LAST 5'h0_010
`define BIT_CNT_RST 5'h0_000

// destination field, top two bits of every word
`define DEST_HI 15
`define DEST_LO 14
`define DEST_CONTROL 2'h0
`define DEST_FREQ_A 2'h1
`define DEST_FREQ_B 2'h2
`define DEST_PHASE 2'h3

// payload layout
`define HALF_BITS 14
`define FREQ_BITS 28
`define PHASE_BITS 12
`define PHASE_SEL_BIT 13

// control bit positions
`define CTL_FULL_WORD 13
`define CTL_HALF_SEL 12
`define CTL_FREQ_CHOICE 11
`define CTL_PHASE_CHOICE 10
`define CTL_SOURCE 9
`define CTL_RESET 8
`define CTL_HALT 7

// reset values
`define CTL_RST_VAL 14'h0_000
`define FREQ_RST_VAL 28'h000_0000
`define PHASE_RST_VAL 12'h000
`define HALF_RST_VAL 14'h0_000

// master clock latencies, in clk_sys cycles
`define SELECT_LATENCY 7
`define RELEASE_LATENCY 7

`endif

// [delay_line.v]
// fixed-depth pipeline used to model master clock latencies
`timescale 1ns/1ps
module delay_line #(
	parameter W = 1,
	parameter D = 1
) (
	input wire clk_sys,
	input wire rst_n,
	input wire [W-1:0] din,
	output wire [W-1:0] dout
);
	// stage 0 is newest, stage d-1 is oldest
	reg [W*D-1:0] stage_q;

	// shift one stage per clock; the depth picks the form so no slice goes negative
	generate
		if (D > 1) begin : g_deep
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					stage_q <= {(W*D){1'b0}};
				end else begin
					stage_q <= {stage_q[W*(D-1)-1:0], din};
				end
			end
		end else begin : g_one
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					stage_q <= {(W*D){1'b0}};
				end else begin
					stage_q <= din;
				end
			end
		end
	endgenerate

	// oldest stage leaves the line
	assign dout = stage_q[W*D-1:W*(D-1)];
endmodule

// [pin_sync.v]
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
	parameter W = 1
) (
	input wire clk_sys,
	input wire rst_n,
	input wire [W-1:0] pin_in,
	output reg [W-1:0] pin_sync_q
);
	// first stage, read only by the second stage
	reg [W-1:0] meta_q;

	// both stages clear to zero; callers invert where idle is high
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= {W{1'b0}};
			pin_sync_q <= {W{1'b0}};
		end else begin
			meta_q <= pin_in;
			pin_sync_q <= meta_q;
		end
	end
endmodule

// [test_dds_serial_control_load.sv]
// self-checking bench for the dds serial control loader
`timescale 1ns/1ps
module test_dds_serial_control_load;
	logic clk_sys = 0;
	logic rst_n = 0;
	logic freq_choice_pin = 0;
	logic phase_choice_pin = 0;
	logic reset_pin = 0;
	logic sleep_pin = 0;
	wire serial_clk, frame_sync_n, serial_data; // from the host model
	wire [13:0] ctl;
	wire [27:0] fa, fb, af;
	wire [11:0] pa, pb, ap;
	wire clr, run, live;
	logic [27:0] fa_e = '0; // expected frequency registers
	logic [27:0] fb_e = '0;
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;
	dds_host_model host (.serial_clk(serial_clk), .frame_sync_n(frame_sync_n),
		.serial_data(serial_data));
	dds_serial_control_load dut (.clk_sys(clk_sys), .rst_n(rst_n), .serial_clk(serial_clk),
		.frame_sync_n(frame_sync_n), .serial_data(serial_data),
		.freq_choice_pin(freq_choice_pin), .phase_choice_pin(phase_choice_pin),
		.reset_pin(reset_pin), .sleep_pin(sleep_pin), .control_bits_q(ctl),
		.frequency_word_a_q(fa), .frequency_word_b_q(fb), .phase_offset_a_q(pa),
		.phase_offset_b_q(pb), .active_freq_q(af), .active_phase_q(ap),
		.accum_clear_q(clr), .accum_run_q(run), .output_live_q(live));
	initial forever #2.5 clk_sys = ~clk_sys;
	// hang guard, far above the expected run length
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 30000) begin
			bad_count++;
			conclude;
		end
	end
	task check(input logic [27:0] got, input logic [27:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// whole words land a few cycles after the last fall, close covers that
	task wr(input logic [15:0] w);
		host.open_frame;
		host.send(w, 16);
		host.close_frame;
	endtask
	// step past the edge so its updates have landed
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task t_power;
		tick(1);
		check(28'(live), 28'h1);
		check(28'(clr), 28'h0);
		tick(1);
		check(28'(run), 28'h1);
		$display("power done");
	endtask
	// full-word load inside one long frame, while the core is held in reset
	task t_full;
		wr(16'h2100);
		check(28'(clr), 28'h1);
		host.open_frame;
		host.send(16'h5555, 16);
		tick(10);
		check(fa, 28'h0);
		host.send(16'h6aaa, 16);
		host.close_frame;
		fa_e = {14'h2aaa, 14'h1555};
		check(fa, fa_e);
		check(28'(clr), 28'h1);
		wr(16'h2000);
		tick(12);
		check(28'(live), 28'h1);
		$display("full done");
	endtask
	task t_half;
		wr(16'h1000);
		wr(16'h8abc);
		fb_e[27:14] = 14'h0abc;
		check(fb, fb_e);
		wr(16'h0000);
		wr(16'h9234);
		fb_e[13:0] = 14'h1234;
		check(fb, fb_e);
		wr(16'h3000);
		host.open_frame;
		host.send(16'h8001, 16);
		host.send(16'h8002, 16);
		host.close_frame;
		fb_e = {14'h0002, 14'h0001};
		check(fb, fb_e);
		check(fa, fa_e);
		$display("half done");
	endtask
	task t_select;
		wr(16'he123);
		wr(16'hc456);
		check(28'(pb), 28'h0123);
		check(28'(pa), 28'h0456);
		wr(16'h0c00);
		tick(12);
		check(28'(ctl), 28'h0c00);
		check(af, fb_e);
		check(28'(ap), 28'h0123);
		wr(16'h0000);
		wr(16'h4777);
		fa_e[13:0] = 14'h0777;
		tick(12);
		check(af, fa_e);
		check(28'(ap), 28'h0456);
		$display("select done");
	endtask
	task t_pins;
		@(posedge clk_sys) freq_choice_pin <= 1;
		@(posedge clk_sys) phase_choice_pin <= 1;
		wr(16'h0200);
		tick(14);
		check(af, fb_e);
		check(28'(ap), 28'h0123);
		@(posedge clk_sys) freq_choice_pin <= 0;
		tick(12);
		check(af, fa_e);
		@(posedge clk_sys) reset_pin <= 1;
		tick(5);
		check(28'(clr), 28'h1);
		@(posedge clk_sys) reset_pin <= 0;
		tick(12);
		check(28'(live), 28'h1);
		@(posedge clk_sys) sleep_pin <= 1;
		tick(5);
		check(28'(run), 28'h0);
		@(posedge clk_sys) sleep_pin <= 0;
		wr(16'h0000);
		$display("pins done");
	endtask
	// halt with the serial clock resting high between frames
	task t_halt;
		host.idle_hi = 1;
		wr(16'h0080);
		tick(4);
		check(28'(run), 28'h0);
		wr(16'h4999);
		check(af, fa_e);
		fa_e[13:0] = 14'h0999;
		wr(16'h0000);
		tick(12);
		check(28'(run), 28'h1);
		check(af, fa_e);
		$display("halt done");
	endtask
	// deselected clocking and a cut-short frame leave no trace
	task t_short;
		host.idle_hi = 0;
		host.stray(6);
		host.open_frame;
		host.send(16'h3fff, 10);
		host.close_frame;
		wr(16'h0005);
		check(28'(ctl), 28'h0005);
		$display("short done");
	endtask
	task conclude;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		rst_n <= 1;
		t_power;
		t_full;
		t_half;
		t_select;
		t_pins;
		t_halt;
		t_short;
		conclude;
	end
endmodule
